/* File: rtl/alr_regs.sv */
// emitter current, ambient parameters and ambient result registers
// Operation
// - the emitter current field at 83h sets the drive to code times 10 mA, 0 to 200 mA, default 20 mA.
// - the upper bits at 83h read a fixed calibration program id that writes never change.
// - the three-bit rate field at 84h selects 1,2,3,4,5,6,8 or 10 samples/s, default code 001.
// - the averaging field sets two to the code conversions per run, one to eight, codes above 3 giving eight, reporting their mean.
// - a rate written during self-timed operation takes effect only once that operation stops.
// - the 16-bit ambient result reads as bytes, high at 85h and low at 86h, read only.
`timescale 1ns/1ns
`include "alr_params.svh"
module alr_regs
    import alr_pkg::*;
#(
    parameter logic [1:0] FUSE_ID = 2'b01  // arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        SELFTIMED_EN,
    input  wire logic        CONV_VALID,
    input  wire logic [15:0] CONV_DATA,
    output logic      [5:0]  LED_CODE,
    output logic      [2:0]  ALS_RATE,
    output logic             CONT_CONV,
    output logic             AUTO_OFFSET,
    output logic             RESULT_VALID
);
    logic [5:0]  led_reg,     led_next;
    alr_byte_t   param_reg,   param_next;
    alr_code_t   rate_reg,    rate_next;
    alr_byte_t   rdata_reg,   rdata_next;
    alr_result_t result_reg,  result_next;
    logic        rv_reg,      rv_next;
    logic        mean_valid;
    alr_result_t mean;
    logic [1:0]  avg_code;

    function automatic alr_byte_t read_mux(input alr_byte_t addr, input logic [5:0] led,
                                           input alr_byte_t param, input alr_result_t res);
        alr_byte_t d;
        d = `ALR_UNMAPPED_DATA;
        case (addr)
            `ALR_OFS_LED_CURRENT: d = {FUSE_ID, led};
            `ALR_OFS_ALS_PARAM:   d = param;
            `ALR_OFS_ALS_RES_HI:  d = res[15:8];
            `ALR_OFS_ALS_RES_LO:  d = res[7:0];
            default:              d = `ALR_UNMAPPED_DATA;
        endcase
        return d;
    endfunction : read_mux

    function automatic logic addr_hit(input logic strobe, input alr_byte_t addr, input alr_byte_t ofs);
        return strobe && (addr == ofs);
    endfunction : addr_hit

    assign avg_code = (param_reg[`ALR_AVG_MSB:`ALR_AVG_LSB] > `ALR_AVG_MAX_CODE) ? 2'd3
                      : param_reg[1:0];

    alr_avg #(
        .WIDTH (16)
    ) u_avg (
        .clk          (CLK),
        .reset_n      (RESET_N),
        .avg_code     (avg_code),
        .sample_valid (CONV_VALID),
        .sample       (CONV_DATA),
        .mean_valid   (mean_valid),
        .mean         (mean)
    );

    // emitter current: over-range codes are clamped, fuse bits are never stored
    always_comb begin
        led_next = led_reg;
        if (addr_hit(REG_WR, REG_ADDR, `ALR_OFS_LED_CURRENT)) begin
            if (REG_WDATA[`ALR_LED_FIELD_MSB:`ALR_LED_FIELD_LSB] > `ALR_LED_MAX_CODE) begin
                led_next = `ALR_LED_LIMIT_CODE;
            end else begin
                led_next = REG_WDATA[`ALR_LED_FIELD_MSB:`ALR_LED_FIELD_LSB];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            led_reg <= `ALR_LED_RESET;
        end else begin
            led_reg <= led_next;
        end
    end

    // ambient parameters; the applied rate only follows while self-timed runs are off
    always_comb begin
        param_next = param_reg;
        rate_next  = rate_reg;
        if (addr_hit(REG_WR, REG_ADDR, `ALR_OFS_ALS_PARAM)) begin
            param_next = REG_WDATA;
        end
        if (!SELFTIMED_EN) begin
            rate_next = param_reg[`ALR_RATE_MSB:`ALR_RATE_LSB];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            param_reg <= `ALR_ALS_PARAM_RESET;
            rate_reg  <= 3'(`ALR_ALS_PARAM_RESET >> `ALR_RATE_LSB);
        end else begin
            param_reg <= param_next;
            rate_reg  <= rate_next;
        end
    end

    // averaged result, replaced whole at the end of each run
    always_comb begin
        result_next = result_reg;
        rv_next     = mean_valid;
        if (mean_valid) begin
            result_next = mean;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            result_reg <= 16'h0000;
            rv_reg     <= 1'b0;
        end else begin
            result_reg <= result_next;
            rv_reg     <= rv_next;
        end
    end

    // read data, registered on the read strobe and held until the next read
    always_comb begin
        rdata_next = rdata_reg;
        if (REG_RD) begin
            rdata_next = read_mux(REG_ADDR, led_reg, param_reg, result_reg);
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA    = rdata_reg;
    assign LED_CODE     = led_reg;
    assign ALS_RATE     = rate_reg;
    assign CONT_CONV    = param_reg[`ALR_CONT_BIT];
    assign AUTO_OFFSET  = param_reg[`ALR_OFFSET_BIT];
    assign RESULT_VALID = rv_reg;

    a_led_limit: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_WR && REG_ADDR == `ALR_OFS_LED_CURRENT && REG_WDATA[5:0] > 6'h14 |=> LED_CODE == 6'h14)
        else $error("over-range emitter code not limited");
    a_led_write: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_WR && REG_ADDR == `ALR_OFS_LED_CURRENT && REG_WDATA[5:0] <= 6'h14
        |=> LED_CODE == $past(REG_WDATA[5:0]))
        else $error("emitter code not stored");
    a_led_range: assert property (@(posedge CLK) disable iff (!RESET_N) LED_CODE <= 6'h14)
        else $error("emitter code above 200 mA");
    a_fuse_fixed: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_RD && REG_ADDR == `ALR_OFS_LED_CURRENT |=> REG_RDATA[7:6] == FUSE_ID)
        else $error("fuse id bits changed");
    a_rate_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        SELFTIMED_EN ##1 SELFTIMED_EN |-> $stable(ALS_RATE))
        else $error("rate changed during self-timed run");
    a_rate_apply: assert property (@(posedge CLK) disable iff (!RESET_N)
        !SELFTIMED_EN |=> ALS_RATE == $past(param_reg[6:4]))
        else $error("rate not applied while idle");
    a_result_hi: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_RD && REG_ADDR == `ALR_OFS_ALS_RES_HI |=> REG_RDATA == $past(result_reg[15:8]))
        else $error("high result byte wrong");
    a_result_lo: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_RD && REG_ADDR == `ALR_OFS_ALS_RES_LO |=> REG_RDATA == $past(result_reg[7:0]))
        else $error("low result byte wrong");
    a_cont_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_WR && REG_ADDR == `ALR_OFS_ALS_PARAM |=> CONT_CONV == $past(REG_WDATA[7]))
        else $error("continuous mode bit not taken");
    a_avg_single: assert property (@(posedge CLK) disable iff (!RESET_N)
        CONV_VALID && avg_code == 2'd0 && u_avg.cnt_reg == 3'd0
        |=> ##1 RESULT_VALID && result_reg == $past(CONV_DATA, 2))
        else $error("single conversion mean wrong");
    a_led_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        !addr_hit(REG_WR, REG_ADDR, `ALR_OFS_LED_CURRENT) |=> $stable(LED_CODE))
        else $error("emitter code changed without a write");
    a_param_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        !addr_hit(REG_WR, REG_ADDR, `ALR_OFS_ALS_PARAM)
        |=> $stable(CONT_CONV) && $stable(AUTO_OFFSET))
        else $error("ambient parameters changed without a write");
    a_offset_bit: assert property (@(posedge CLK) disable iff (!RESET_N)
        addr_hit(REG_WR, REG_ADDR, `ALR_OFS_ALS_PARAM)
        |=> AUTO_OFFSET == $past(REG_WDATA[`ALR_OFFSET_BIT]))
        else $error("offset compensation bit not taken");
    a_result_ro: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_WR && (REG_ADDR == `ALR_OFS_ALS_RES_HI || REG_ADDR == `ALR_OFS_ALS_RES_LO) && !mean_valid
        |=> $stable(result_reg))
        else $error("result changed by a host write");
    a_rdata_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
    a_unmapped_read: assert property (@(posedge CLK) disable iff (!RESET_N)
        REG_RD && !(REG_ADDR inside {[`ALR_OFS_LED_CURRENT:`ALR_OFS_ALS_RES_LO]})
        |=> REG_RDATA == `ALR_UNMAPPED_DATA)
        else $error("unmapped read not zero");
    a_avg_count: assert property (@(posedge CLK) disable iff (!RESET_N)
        {1'b0, u_avg.cnt_reg} < (4'd1 << u_avg.code_reg))
        else $error("conversion count beyond the run length");
    a_result_take: assert property (@(posedge CLK) disable iff (!RESET_N)
        mean_valid |=> RESULT_VALID && result_reg == $past(mean))
        else $error("averaged result not stored");
endmodule : alr_regs

/* File: rtl/alr_params.svh */
// offsets, field positions, reset values and limits of the ambient light register block
`ifndef ALR_PARAMS_SVH
`define ALR_PARAMS_SVH

`define ALR_OFS_LED_CURRENT   8'h83
`define ALR_OFS_ALS_PARAM     8'h84
`define ALR_OFS_ALS_RES_HI    8'h85
`define ALR_OFS_ALS_RES_LO    8'h86

`define ALR_LED_FIELD_MSB     5
`define ALR_LED_FIELD_LSB     0
`define ALR_FUSE_MSB          7
`define ALR_FUSE_LSB          6
`define ALR_LED_RESET         6'h02
`define ALR_LED_MAX_CODE      6'h14
`define ALR_LED_LIMIT_CODE    6'h14
`define ALR_LED_STEP_MA       10

`define ALR_CONT_BIT          7
`define ALR_RATE_MSB          6
`define ALR_RATE_LSB          4
`define ALR_OFFSET_BIT        3
`define ALR_AVG_MSB           2
`define ALR_AVG_LSB           0
`define ALR_AVG_MAX_CODE      3'h3
`define ALR_ALS_PARAM_RESET   8'h18

`define ALR_UNMAPPED_DATA     8'h00

`endif

/* File: rtl/alr_pkg.sv */
// types shared by the ambient light register block
package alr_pkg;
    typedef logic [7:0]  alr_byte_t;
    typedef logic [15:0] alr_result_t;
    typedef logic [2:0]  alr_code_t;
endpackage : alr_pkg

/* File: rtl/alr_avg.sv */
// averaging of single conversions into one ambient result
`timescale 1ns/1ns
module alr_avg
    import alr_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [1:0]       avg_code,
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample,
    output logic                  mean_valid,
    output logic      [WIDTH-1:0] mean
);
    logic [WIDTH+2:0] acc_reg,  acc_next;
    logic [2:0]       cnt_reg,  cnt_next;
    logic [1:0]       code_reg, code_next;
    logic             mv_reg,   mv_next;
    logic [WIDTH-1:0] mean_reg, mean_next;
    logic [WIDTH+2:0] sum;

    always_comb begin
        acc_next  = acc_reg;
        cnt_next  = cnt_reg;
        code_next = code_reg;
        mv_next   = 1'b0;
        mean_next = mean_reg;
        sum       = acc_reg + {3'b000, sample};
        if (sample_valid) begin
            if (cnt_reg == 3'd0) begin
                code_next = avg_code;
                sum       = {3'b000, sample};
            end
            if (cnt_reg == 3'((1 << ((cnt_reg == 3'd0) ? avg_code : code_reg)) - 1)) begin
                mean_next = WIDTH'(sum >> ((cnt_reg == 3'd0) ? avg_code : code_reg));
                mv_next   = 1'b1;
                cnt_next  = 3'd0;
                acc_next  = '0;
            end else begin
                cnt_next = cnt_reg + 3'd1;
                acc_next = sum;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg  <= '0;
            cnt_reg  <= 3'd0;
            code_reg <= 2'd0;
            mv_reg   <= 1'b0;
            mean_reg <= '0;
        end else begin
            acc_reg  <= acc_next;
            cnt_reg  <= cnt_next;
            code_reg <= code_next;
            mv_reg   <= mv_next;
            mean_reg <= mean_next;
        end
    end

    assign mean_valid = mv_reg;
    assign mean       = mean_reg;
endmodule : alr_avg

/* File: verif/alr_conv_src.sv */
// conversion source model feeding single ambient conversions
`timescale 1ns/1ns
module alr_conv_src
    import alr_pkg::*;
(
    input  wire logic   clk,
    output logic        conv_valid,
    output alr_result_t conv_data
);
    initial begin
        conv_valid = 1'b0;
        conv_data  = 16'h0000;
    end
    // one pulse per conversion, back to back; data line set to the inverse of the last sample once the run ends
    task automatic send(input alr_result_t d[8], input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            conv_valid <= 1'b1;
            conv_data  <= d[i];
        end
        @(posedge clk);
        conv_valid <= 1'b0;
        conv_data  <= ~d[n-1];
    endtask : send
endmodule : alr_conv_src

/* File: verif/ambient_light_config_and_result_test.sv */
// self-checking bench for the ambient light register block
`timescale 1ns/1ns
module ambient_light_config_and_result_test;
    import alr_pkg::*;
    localparam logic [1:0] FUSE = 2'b01;  // arbitrary value
    logic clk, reset_n, reg_wr, reg_rd, st_en, conv_valid, cont_conv, auto_offset, result_valid, rd_seen;
    alr_byte_t   reg_addr, reg_wdata, reg_rdata, exp_b;
    alr_byte_t   exp_q[$];
    alr_result_t conv_data, mean;
    alr_result_t d[8];
    logic [5:0]  led_code, code, exp_led;
    alr_code_t   als_rate;
    int          failures, check_count, cycles, seed, waited, sum, n, av;
    logic [5:0]  edge_codes[5] = '{6'h00, 6'h13, 6'h14, 6'h15, 6'h3F};

    alr_regs #(.FUSE_ID(FUSE)) uut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SELFTIMED_EN(st_en), .CONV_VALID(conv_valid),
        .CONV_DATA(conv_data), .LED_CODE(led_code), .ALS_RATE(als_rate), .CONT_CONV(cont_conv),
        .AUTO_OFFSET(auto_offset), .RESULT_VALID(result_valid));
    alr_conv_src src (.clk(clk), .conv_valid(conv_valid), .conv_data(conv_data));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic wr(input alr_byte_t a, input alr_byte_t v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input alr_byte_t a, input alr_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask : rd
    // read data is due one cycle after the read edge
    always @(negedge clk) begin
        if (rd_seen) begin
            exp_b = exp_q.pop_front();
            chk("reg_rdata", 16'(reg_rdata), 16'(exp_b));
        end
        rd_seen = reg_rd;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        seed = 97; reset_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        st_en = 1'b0; rd_seen = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("led_code", 16'(led_code), 16'h0002);
        chk("als_rate", 16'(als_rate), 16'h0001);
        chk("cont_conv", 16'(cont_conv), 16'h0000);
        chk("auto_offset", 16'(auto_offset), 16'h0001);
        rd(8'h83, {FUSE, 6'h02});
        rd(8'h84, 8'h18);
        rd(8'h85, 8'h00);
        rd(8'h86, 8'h00);
        wr(8'h87, 8'hAA);
        rd(8'h87, 8'h00);
        for (int i = 0; i < 12; i++) begin
            code = (i < 5) ? edge_codes[i] : 6'($random(seed));
            exp_led = (code > 6'h14) ? 6'h14 : code;
            wr(8'h83, {2'b10, code});
            @(negedge clk);
            chk("led_code", 16'(led_code), 16'(exp_led));
            rd(8'h83, {FUSE, exp_led});
        end
        for (int r = 0; r < 8; r++) begin
            wr(8'h84, {1'b1, 3'(r), 4'h0});
            @(posedge clk);
            @(negedge clk);
            chk("als_rate", 16'(als_rate), 16'(r));
            chk("cont_conv", 16'(cont_conv), 16'h0001);
            chk("auto_offset", 16'(auto_offset), 16'h0000);
            rd(8'h84, {1'b1, 3'(r), 4'h0});
        end
        wr(8'h84, 8'h28);
        @(negedge clk);
        chk("cont_conv", 16'(cont_conv), 16'h0000);
        chk("auto_offset", 16'(auto_offset), 16'h0001);
        @(posedge clk);
        st_en <= 1'b1;
        wr(8'h84, 8'h58);
        @(negedge clk);
        chk("als_rate", 16'(als_rate), 16'h0002);
        @(posedge clk);
        st_en <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("als_rate", 16'(als_rate), 16'h0005);
        for (int a = 0; a < 5; a++) begin
            av = (a == 4) ? 7 : a;
            wr(8'h84, 8'h18 | 8'(av));
            av = (av > 3) ? 3 : av;
            n = 1 << av;
            sum = 0;
            for (int i = 0; i < 8; i++) begin
                d[i] = 16'($random(seed));
                if (i < n) sum += d[i];
            end
            src.send(d, n);
            waited = 0;
            while (result_valid !== 1'b1 && waited < 10) begin
                @(negedge clk);
                waited++;
            end
            chk("result_delay", 16'(waited), 16'h0002);
            mean = 16'(sum >> av);
            wr(8'h85, 8'hFF);
            rd(8'h85, mean[15:8]);
            rd(8'h86, mean[7:0]);
        end
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("led_code", 16'(led_code), 16'h0002);
        chk("als_rate", 16'(als_rate), 16'h0001);
        chk("cont_conv", 16'(cont_conv), 16'h0000);
        chk("auto_offset", 16'(auto_offset), 16'h0001);
        chk("result_valid", 16'(result_valid), 16'h0000);
        rd(8'h84, 8'h18);
        rd(8'h85, 8'h00);
        rd(8'h86, 8'h00);
        repeat (3) @(posedge clk);
        stop_test();
    end
endmodule : ambient_light_config_and_result_test
